//--- rtl/bank_state_tracker.sv
// Open/idle state of every bank, with per-bank and all-bank precharge.
// Assumes activation and precharge strobes are one-cycle pulses.
module bank_state_tracker
  import sdram_wp_pkg::*;
#(
  parameter int NBANKS = BANKS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic activate,
  input wire logic precharge,
  input wire logic precharge_all,
  input wire logic [1:0] bank,
  output logic [NBANKS-1:0] open_banks
);

  typedef struct packed {
    logic [NBANKS-1:0] open_banks;
  } state_type;

  state_type state_reg;
  state_type state_next;

  always_comb begin
    state_next = state_reg;
    for (int b = 0; b < NBANKS; b++) begin
      if (precharge_all) begin
        state_next.open_banks[b] = 1'b0;
      end else if (precharge && bank == 2'(b)) begin
        state_next.open_banks[b] = 1'b0;
      end else if (activate && bank == 2'(b)) begin
        state_next.open_banks[b] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign open_banks = state_reg.open_banks;

endmodule

//--- rtl/burst_address_gen.sv
// Column address generator for one burst word.
// Assumes start column, word index and mode fields are stable in the cycle.
module burst_address_gen
  import sdram_wp_pkg::*;
#(
  parameter int COLS = COL_W
) (
  input wire logic [COLS-1:0] start_col,
  input wire logic [COLS-1:0] index,
  input wire logic [2:0] burst_code,
  input wire logic interleave,
  output logic [COLS-1:0] col
);

  logic [COLS-1:0] wrap_mask;
  logic [COLS-1:0] sum;

  always_comb begin
    case (burst_code)
      BL_TWO: wrap_mask = COLS'(1);
      BL_FOUR: wrap_mask = COLS'(3);
      BL_EIGHT: wrap_mask = COLS'(7);
      BL_PAGE: wrap_mask = '1;
      default: wrap_mask = '0;
    endcase
    sum = start_col + index;
    if (interleave && burst_code != BL_PAGE) begin
      col = start_col ^ (index & wrap_mask);
    end else begin
      // Page bursts wrap at the top column by natural overflow
      col = (start_col & ~wrap_mask) | (sum & wrap_mask);
    end
  end

endmodule

//--- rtl/sdram_wp_core.sv
// Write, precharge, page-mode and burst-termination control with mode register.
// Assumes commands are already decoded on ref_clk; no array storage lives here.
//
// Contract
// - Write after activate delay; capture each edge
// - Auto-precharge write closes bank after burst
// - Precharge ends write burst same cycle
// - Full page writes continue until stop/precharge
// - Single-write mode writes exactly one word; page bursts ignore it and run until stop/precharge
// - Bank precharge closes only addressed bank
// - Precharge all accepted; all banks idle
// - New read/write accepted any cycle
// - Read interrupting write drops later data
// - Precharge stops read after latency minus one
// - Burst stop ends page read likewise
// - Burst stop ends page write immediately
// - Mode load from address and bank bits
// - Burst length from mode bits two..zero
// - Mode bit three selects address order
// - Interleave lacks full page support
// - Sequential increments, wrapping low bits
// - Interleave XORs low bits with index
// - Read latency from mode bits six..four
// - Mode bit nine selects single writes
// - Mask blocks write now, read later
module sdram_wp_core
  import sdram_wp_pkg::*;
#(
  parameter int COLS = COL_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire request_type request,
  input wire logic data_mask,
  output access_type write_access,
  output access_type read_access,
  output logic read_drive,
  output logic [BANKS-1:0] open_banks,
  output logic [MODE_W-1:0] operating_mode_register,
  output logic write_busy,
  output logic read_busy
);

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BURST,
    WR_AUTO_PRE
  } write_state_type;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    write_state_type wstate;
    logic [1:0] wbank;
    logic [COLS-1:0] wstart;
    logic [COLS-1:0] windex;
    logic wauto;
    logic rbusy;
    logic [1:0] rbank;
    logic [COLS-1:0] rstart;
    logic [COLS-1:0] rindex;
    logic rauto;
    logic [3:0] rpipe;
    logic [3:0] rstop_pipe;
    logic [MASK_READ_DELAY-1:0] mask_pipe;
    logic auto_pre_pulse;
    logic [1:0] auto_pre_bank;
    access_type wacc;
    access_type racc;
    logic drive;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [2:0] burst_code;
  logic interleave;
  logic single_write;
  logic [2:0] latency_code;
  logic [COLS-1:0] burst_words;
  logic [COLS-1:0] write_col;
  logic [COLS-1:0] read_col;
  logic is_write;
  logic is_read;
  logic is_pre;
  logic is_stop;
  logic write_word;
  logic write_last;
  logic read_word;
  logic read_last;
  logic page_mode;
  logic [3:0] stop_at;

  assign burst_code = state_reg.mode[MODE_BL_LSB +: 3];
  assign interleave = state_reg.mode[MODE_ORDER_BIT];
  assign single_write = state_reg.mode[MODE_SINGLE_WRITE_BIT];
  assign latency_code = state_reg.mode[MODE_CL_LSB +: 3];
  // Interleave cannot run a page burst, so it falls back to sequential
  assign page_mode = (burst_code == BL_PAGE);

  always_comb begin
    case (burst_code)
      BL_TWO: burst_words = COLS'(2);
      BL_FOUR: burst_words = COLS'(4);
      BL_EIGHT: burst_words = COLS'(8);
      default: burst_words = COLS'(1);
    endcase
  end

  assign is_write = request.cmd == CMD_WRITE;
  assign is_read = request.cmd == CMD_READ;
  assign is_pre = request.cmd == CMD_PRECHARGE;
  assign is_stop = request.cmd == CMD_BURST_STOP;
  // Latency minus one; code three or two only, others treated as two
  assign stop_at = (latency_code == CL_THREE) ? 4'h2 : 4'h1;

  burst_address_gen #(
    .COLS(COLS)
  ) write_addr (
    .start_col(state_reg.wstart),
    .index(state_reg.windex),
    .burst_code(burst_code),
    .interleave(interleave),
    .col(write_col)
  );

  burst_address_gen #(
    .COLS(COLS)
  ) read_addr (
    .start_col(state_reg.rstart),
    .index(state_reg.rindex),
    .burst_code(burst_code),
    .interleave(interleave),
    .col(read_col)
  );

  bank_state_tracker #(
    .NBANKS(BANKS)
  ) banks (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .activate(request.cmd == CMD_ACTIVATE),
    .precharge((is_pre && !request.all_banks) || state_reg.auto_pre_pulse),
    .precharge_all(is_pre && request.all_banks),
    .bank(state_reg.auto_pre_pulse ? state_reg.auto_pre_bank : request.bank),
    .open_banks(open_banks)
  );

  // A word is stored in the cycle its data is on the bus
  assign write_word = state_reg.wstate == WR_BURST;
  assign write_last = !page_mode && (single_write ||
    state_reg.windex == burst_words - COLS'(1));
  assign read_word = state_reg.rbusy;
  assign read_last = !page_mode && state_reg.rindex == burst_words - COLS'(1);

  always_comb begin
    state_next = state_reg;
    state_next.auto_pre_pulse = 1'b0;
    state_next.wacc = '0;
    state_next.racc = '0;
    state_next.mask_pipe = {state_reg.mask_pipe[MASK_READ_DELAY-2:0], data_mask};
    state_next.rpipe = {state_reg.rpipe[2:0], 1'b0};
    state_next.rstop_pipe = {state_reg.rstop_pipe[2:0], 1'b0};

    // Write data path: word taken on each edge after the command
    if (write_word) begin
      state_next.wacc.valid = !data_mask;
      state_next.wacc.bank = state_reg.wbank;
      state_next.wacc.col = write_col;
      state_next.windex = state_reg.windex + COLS'(1);
      if (write_last) begin
        state_next.wstate = state_reg.wauto ? WR_AUTO_PRE : WR_IDLE;
      end
    end
    if (state_reg.wstate == WR_AUTO_PRE) begin
      // Internal precharge follows the last written word
      state_next.auto_pre_pulse = 1'b1;
      state_next.auto_pre_bank = state_reg.wbank;
      state_next.wstate = WR_IDLE;
    end

    // Read column walk; data timing is a latency pipe
    if (read_word) begin
      state_next.racc.valid = 1'b1;
      state_next.racc.bank = state_reg.rbank;
      state_next.racc.col = read_col;
      state_next.rpipe[0] = 1'b1;
      state_next.rindex = state_reg.rindex + COLS'(1);
      if (read_last) begin
        state_next.rbusy = 1'b0;
        if (state_reg.rauto) begin
          state_next.auto_pre_pulse = 1'b1;
          state_next.auto_pre_bank = state_reg.rbank;
        end
      end
    end

    // Terminations: write stops in the same cycle as the command
    if ((is_pre && (request.all_banks || request.bank == state_reg.wbank))
        && state_reg.wstate == WR_BURST) begin
      state_next.wacc.valid = 1'b0;
      state_next.wstate = WR_IDLE;
    end
    if (is_stop && page_mode && state_reg.wstate == WR_BURST) begin
      state_next.wacc.valid = 1'b0;
      state_next.wstate = WR_IDLE;
    end
    if ((is_pre && (request.all_banks || request.bank == state_reg.rbank)) ||
        (is_stop && page_mode)) begin
      if (state_reg.rbusy) begin
        state_next.rbusy = 1'b0;
        state_next.racc.valid = 1'b0;
        state_next.rpipe[0] = 1'b0;
        // Output ends latency minus one cycles later
        state_next.rstop_pipe = {state_reg.rstop_pipe[2:0], 1'b1};
      end
    end

    // New column commands preempt any running burst
    if (is_read) begin
      if (state_reg.wstate == WR_BURST) begin
        state_next.wacc.valid = 1'b0;
        state_next.wstate = WR_IDLE;
      end
      state_next.rbusy = 1'b1;
      state_next.rbank = request.bank;
      state_next.rstart = request.col;
      state_next.rindex = '0;
      state_next.rauto = request.auto_pre;
    end
    if (is_write) begin
      state_next.rbusy = 1'b0;
      state_next.rpipe[0] = 1'b0;
      state_next.wstate = WR_BURST;
      state_next.wbank = request.bank;
      state_next.wstart = request.col;
      state_next.windex = '0;
      state_next.wauto = request.auto_pre;
    end
    if (request.cmd == CMD_MODE_LOAD) begin
      state_next.mode = request.mode_bits;
    end

    // Read drive follows latency unless stopped or masked two cycles back
    state_next.drive = (latency_code == CL_THREE ? state_reg.rpipe[1] : state_reg.rpipe[0])
      && !(state_reg.rstop_pipe[stop_at[1:0] - 2'h1])
      && !state_reg.mask_pipe[MASK_READ_DELAY-1];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.mode <= MODE_RESET;
      state_reg.wstate <= WR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign write_access = state_reg.wacc;
  assign read_access = state_reg.racc;
  assign read_drive = state_reg.drive;
  assign operating_mode_register = state_reg.mode;
  assign write_busy = state_reg.wstate != WR_IDLE;
  assign read_busy = state_reg.rbusy;

endmodule

//--- rtl/sdram_wp_pkg.sv
// Shared constants and carriers for the write, precharge and page-mode logic.
// Assumes one 100 MHz clock; command decode is done on the same clock.
package sdram_wp_pkg;

  localparam int BANKS = 4;
  localparam int COL_W = 10;
  localparam int MODE_W = 15;

  // Mode register field positions
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_ORDER_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_SINGLE_WRITE_BIT = 9;

  // Burst length codes
  localparam logic [2:0] BL_ONE = 3'h0;
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Read latency codes
  localparam logic [2:0] CL_TWO = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;

  // Mode register holds an undefined value until loaded; zero is used here
  localparam logic [MODE_W-1:0] MODE_RESET = 15'h0000;

  // Output-disable delay after a high data mask on reads
  localparam int MASK_READ_DELAY = 2;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_BURST_STOP,
    CMD_MODE_LOAD,
    CMD_REFRESH
  } command_type;

  typedef struct packed {
    command_type cmd;
    logic [1:0] bank;
    logic auto_pre;
    logic all_banks;
    logic [COL_W-1:0] col;
    logic [MODE_W-1:0] mode_bits;
  } request_type;

  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [COL_W-1:0] col;
  } access_type;

endpackage

//--- verif/sdram_ctrl_model.sv
// Memory controller model: one command per cycle, changed at falling edges.
// Assumes the bench calls its tasks in order; idle command is NOP.
module sdram_ctrl_model
  import sdram_wp_pkg::*;
#(
  parameter int ACT_DELAY = 2
) (
  input wire logic ref_clk,
  output request_type request,
  output logic data_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    request = '0;
    data_mask = 1'b0;
  end
  task automatic send(input command_type c, input logic [1:0] b, input logic [COL_W-1:0] a,
    input logic ap, input logic m);
    @(negedge ref_clk);
    request <= '{c, b, ap, ap, a, {5'h00, a}};
    data_mask <= m;
  endtask
  task automatic idle(input int n);
    repeat (n) send(CMD_NOP, 2'h0, 10'h000, 1'b0, 1'b0);
  endtask
  task automatic open_bank(input logic [1:0] b);
    send(CMD_ACTIVATE, b, 10'h000, 1'b0, 1'b0);
    idle(ACT_DELAY);
  endtask
  task automatic load_mode(input logic [COL_W-1:0] m);
    send(CMD_PRECHARGE, 2'h0, 10'h000, 1'b1, 1'b0);
    send(CMD_MODE_LOAD, 2'h0, m, 1'b0, 1'b0);
    idle(1);
  endtask
endmodule

//--- verif/sdram_wp_core_properties.sv
// Checker on the core's ports: mode, bank and write-slot relations.
// Assumes requests change at falling edges of ref_clk.
module sdram_wp_core_properties
  import sdram_wp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire request_type request,
  input wire logic data_mask,
  input wire access_type write_access,
  input wire access_type read_access,
  input wire logic read_drive,
  input wire logic [BANKS-1:0] open_banks,
  input wire logic [MODE_W-1:0] operating_mode_register,
  input wire logic write_busy,
  input wire logic read_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] bl;
  assign bl = operating_mode_register[2:0];
  sequence wr_single_s;
    request.cmd == CMD_WRITE && operating_mode_register[MODE_SINGLE_WRITE_BIT];
  endsequence
  sequence quiet2_s;
    (request.cmd == CMD_NOP) [*2];
  endsequence
  mode_load_a: assert property (request.cmd == CMD_MODE_LOAD |=>
    operating_mode_register == $past(request.mode_bits)) else $error("mode load lost");
  all_idle_a: assert property (request.cmd == CMD_PRECHARGE && request.all_banks |=>
    open_banks == '0) else $error("bank open after precharge all");
  one_bank_a: assert property (request.cmd == CMD_PRECHARGE && !request.all_banks |=>
    open_banks == ($past(open_banks) & ~(4'h1 << $past(request.bank))))
    else $error("wrong banks closed");
  mask_slot_a: assert property (data_mask |=> !write_access.valid)
    else $error("masked word stored");
  stop_write_a: assert property (write_busy &&
    request.cmd inside {CMD_BURST_STOP, CMD_PRECHARGE} |=> !write_access.valid)
    else $error("word stored after stop");
  read_cut_a: assert property (write_busy && request.cmd == CMD_READ |=>
    !write_access.valid) else $error("word stored after read");
  page_run_a: assert property (write_busy && bl == BL_PAGE &&
    request.cmd == CMD_NOP && !data_mask |=> write_access.valid) else $error("page word missing");
  single_word_a: assert property (wr_single_s ##1 quiet2_s |=>
    !write_access.valid) else $error("second word in single write");
  read_stop_a: assert property (read_busy && request.cmd == CMD_PRECHARGE |->
    ##[1:3] !read_drive) else $error("read output kept after precharge");
endmodule

bind sdram_wp_core sdram_wp_core_properties i_sdram_wp_core_properties(.ref_clk(ref_clk),
  .rst_n(rst_n), .request(request), .data_mask(data_mask), .write_access(write_access),
  .read_access(read_access), .read_drive(read_drive), .open_banks(open_banks),
  .operating_mode_register(operating_mode_register), .write_busy(write_busy),
  .read_busy(read_busy));

//--- verif/sdram_write_precharge_mode_logic_bench.sv
// Self-checking bench for the write, precharge and mode logic.
// Assumes the controller model and the bound checker are compiled alongside.
module sdram_write_precharge_mode_logic_bench;
  import sdram_wp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst_n;
  request_type request;
  logic data_mask;
  access_type write_access;
  access_type read_access;
  logic read_drive;
  logic write_busy;
  logic read_busy;
  logic [BANKS-1:0] open_banks;
  logic [MODE_W-1:0] mode;
  int error_cnt = 0;
  int samples_checked = 0;
  access_type exp_q[$];
  logic [COL_W-1:0] s;
  logic [COL_W-1:0] cur;
  logic [COL_W-1:0] modes[6] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h00A, 10'h00B};

  sdram_ctrl_model i_sdram_ctrl_model(.ref_clk(ref_clk), .request(request),
    .data_mask(data_mask));
  sdram_wp_core i_sdram_wp_core(.ref_clk(ref_clk), .rst_n(rst_n), .request(request),
    .data_mask(data_mask), .write_access(write_access), .read_access(read_access),
    .read_drive(read_drive), .open_banks(open_banks), .operating_mode_register(mode),
    .write_busy(write_busy), .read_busy(read_busy));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] a, input int i);
    logic [COL_W-1:0] m;
    m = (cur[2:0] == BL_PAGE) ? '1 : COL_W'((1 << cur[2:0]) - 1);
    return cur[3] ? (a ^ COL_W'(i)) : ((a & ~m) | ((a + COL_W'(i)) & m));
  endfunction

  // Masked slots get no note, so a stored masked word shows as a mismatch
  task automatic wr(input logic [1:0] b, input logic [COL_W-1:0] a, input int nd,
    input int nn, input command_type t, input logic ap);
    logic m;
    i_sdram_ctrl_model.send(CMD_WRITE, b, a, ap, 1'b0);
    for (int i = 0; i < nn; i++) begin
      m = $urandom_range(0, 3) == 0;
      i_sdram_ctrl_model.send(CMD_NOP, b, a, 1'b0, m);
      if (i < nd && !m) exp_q.push_back('{1'b1, b, burst_col(a, i)});
    end
    i_sdram_ctrl_model.send(t, b, a, 1'b0, t != CMD_NOP);
    i_sdram_ctrl_model.idle(1);
  endtask

  task automatic setm(input logic [COL_W-1:0] m);
    cur = m;
    i_sdram_ctrl_model.load_mode(m);
    check(16'(mode), 16'(m));
  endtask

  always @(negedge ref_clk) begin
    if (rst_n === 1'b1 && write_access.valid !== 1'b0) begin
      if (exp_q.size() == 0) check(16'(write_access), 16'h0000);
      else check(16'(write_access), 16'(exp_q.pop_front()));
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("ERROR %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    s = 10'($urandom(79041));
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    check(16'(mode), 16'(MODE_RESET));
    foreach (modes[k]) begin
      setm(modes[k]);
      i_sdram_ctrl_model.open_bank(2'h0);
      check(16'(open_banks), 16'h0001);
      s = (k == 5) ? 10'h00D : 10'($urandom);
      wr(2'h0, s, 1 << modes[k][2:0], 1 << modes[k][2:0], CMD_NOP, 1'b0);
      $display("test burst mode %h done", modes[k]);
    end
    setm(10'h007);
    i_sdram_ctrl_model.open_bank(2'h0);
    wr(2'h0, 10'h3FE, 5, 5, CMD_BURST_STOP, 1'b0);
    setm(10'h203);
    i_sdram_ctrl_model.open_bank(2'h0);
    wr(2'h0, 10'($urandom), 1, 4, CMD_NOP, 1'b0);
    setm(10'h003);
    i_sdram_ctrl_model.open_bank(2'h0);
    wr(2'h0, 10'($urandom), 3, 3, CMD_READ, 1'b0);
    check(16'(read_busy), 16'h0001);
    check(16'(write_busy), 16'h0000);
    i_sdram_ctrl_model.send(CMD_PRECHARGE, 2'h0, 10'h000, 1'b0, 1'b0);
    i_sdram_ctrl_model.idle(4);
    check(16'(read_busy), 16'h0000);
    check(16'(read_drive), 16'h0000);
    check(16'(read_access.valid), 16'h0000);
    $display("test page and interrupt done");
    i_sdram_ctrl_model.open_bank(2'h0);
    i_sdram_ctrl_model.open_bank(2'h1);
    wr(2'h0, 10'($urandom), 2, 2, CMD_PRECHARGE, 1'b0);
    check(16'(open_banks), 16'h0002);
    setm(10'h002);
    i_sdram_ctrl_model.open_bank(2'h1);
    i_sdram_ctrl_model.open_bank(2'h0);
    wr(2'h0, 10'($urandom), 4, 4, CMD_NOP, 1'b1);
    i_sdram_ctrl_model.idle(3);
    check(16'(open_banks), 16'h0002);
    $display("test precharge done");
    i_sdram_ctrl_model.idle(4);
    check(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
